// [sram_port_pkg.sv]
// Purpose: Shared types and constants for the pipelined burst static memory port.
// Assumes: Controller logic runs on the same clock as the memory port.
// Notes:   Each struct field takes its widest width over both organisations; narrower builds zero the top bits, but write lanes come out set there.
package sram_port_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_MAX   = 18;
  localparam int LANE_MAX   = 4;
  localparam int LANE_BITS  = 9;
  localparam int ADDR_X36   = 17;
  localparam int ADDR_X18   = 18;
  localparam int LANES_X36  = 4;
  localparam int LANES_X18  = 2;
  localparam int BURST_BITS = 2;

  // ----------------------------------------------------------------
  // Pipeline carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                sel;
    logic                load;
    logic                rd;
    logic                order;
    logic [ADDR_MAX-1:0] addr;
    logic [LANE_MAX-1:0] lanes_n;
  } pin_t;

  typedef struct packed {
    logic                valid;
    logic                write;
    logic [ADDR_MAX-1:0] addr;
    logic [LANE_MAX-1:0] lanes;
  } cmd_t;

  typedef logic [BURST_BITS-1:0] burst_t;

  // ----------------------------------------------------------------
  // Values after reset and the burst step
  // ----------------------------------------------------------------
  localparam pin_t   PIN_RST   = '{sel: 1'h0, load: 1'h0, rd: 1'h1, order: 1'h0,
                                   addr: 18'h0_0000, lanes_n: 4'hF};
  localparam cmd_t   CMD_IDLE  = '{valid: 1'h0, write: 1'h0, addr: 18'h0_0000, lanes: 4'h0};
  localparam burst_t BURST_RST = 2'h0;
  localparam burst_t BURST_ONE = 2'h1;

endpackage : sram_port_pkg

// [pipelined_burst_sram_port.sv]
// Purpose: Synchronous pipelined static memory with a four-word burst counter.
// Assumes: The controller is clocked by CORE_CLK, so its pins need no synchroniser.
// Notes:   DATA_OE_N also follows OUTPUT_ENABLE_N without a clock edge in between.
module pipelined_burst_sram_port #(
  parameter bit ORG_X36 = 1'h1,
  localparam int ADDR_W = ORG_X36 ? sram_port_pkg::ADDR_X36 : sram_port_pkg::ADDR_X18,
  localparam int LANES  = ORG_X36 ? sram_port_pkg::LANES_X36 : sram_port_pkg::LANES_X18,
  localparam int DATA_W = LANES * sram_port_pkg::LANE_BITS
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              CLOCK_SUSPEND_N,
  input  wire logic              CHIP_SELECT_LOW_A,
  input  wire logic              CHIP_SELECT_LOW_B,
  input  wire logic              CHIP_SELECT_PAIR,
  input  wire logic              ADVANCE_OR_LOAD,
  input  wire logic              READ_NOT_WRITE,
  input  wire logic [ADDR_W-1:0] WORD_ADDRESS,
  input  wire logic [LANES-1:0]  BYTE_LANE_WRITE_N,
  input  wire logic              BURST_ORDER_SEL,
  input  wire logic              OUTPUT_ENABLE_N,
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic      [DATA_W-1:0] DATA_OUT,
  output logic                   DATA_OE_N
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sram_port_pkg::pin_t   in_q;
  sram_port_pkg::cmd_t   s1;
  sram_port_pkg::cmd_t   s2;
  sram_port_pkg::cmd_t   next_cmd;
  sram_port_pkg::burst_t base;
  sram_port_pkg::burst_t cnt;
  sram_port_pkg::burst_t next_base;
  sram_port_pkg::burst_t next_cnt;
  logic                  active;
  logic                  next_active;
  logic                  bwrite;
  logic                  next_bwrite;
  logic [ADDR_W-1:0]     hi;
  logic [ADDR_W-1:0]     next_hi;
  logic                  drive;
  logic [DATA_W-1:0]     din_q;
  logic [DATA_W-1:0]     rd_word;
  logic [DATA_W-1:0]     wr_word;
  logic [DATA_W-1:0]     mem [2**ADDR_W];
  logic                  run;
  logic                  hit;

  // The suspend pin acts as if the edge never came: every register below holds.
  assign run = !CLOCK_SUSPEND_N;

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      in_q <= sram_port_pkg::PIN_RST;
    end else if (run) begin
      in_q.sel     <= !CHIP_SELECT_LOW_A && !CHIP_SELECT_LOW_B && CHIP_SELECT_PAIR;
      in_q.load    <= !ADVANCE_OR_LOAD;
      in_q.rd      <= READ_NOT_WRITE;
      in_q.order   <= BURST_ORDER_SEL;
      in_q.addr    <= sram_port_pkg::ADDR_MAX'(WORD_ADDRESS);
      in_q.lanes_n <= sram_port_pkg::LANE_MAX'(BYTE_LANE_WRITE_N);
    end
  end

  // ----------------------------------------------------------------
  // Command decode and burst counter
  // ----------------------------------------------------------------
  always_comb begin
    next_cmd    = sram_port_pkg::CMD_IDLE;
    next_base   = base;
    next_cnt    = cnt;
    next_active = active;
    next_bwrite = bwrite;
    next_hi     = hi;
    if (in_q.load) begin
      if (in_q.sel) begin
        next_cmd.valid = 1'h1;
        next_cmd.write = !in_q.rd;
        next_cmd.addr  = in_q.addr;
        // Lane selects only matter for writes.
        next_cmd.lanes = in_q.rd ? '0 : ~in_q.lanes_n;
        next_base      = in_q.addr[sram_port_pkg::BURST_BITS-1:0];
        next_cnt       = sram_port_pkg::BURST_RST;
        next_active    = 1'h1;
        next_bwrite    = !in_q.rd;
        next_hi        = in_q.addr[ADDR_W-1:0];
      end else begin
        next_active = 1'h0;
      end
    end else if (active) begin
      next_cnt       = cnt + sram_port_pkg::BURST_ONE;
      next_cmd.valid = 1'h1;
      next_cmd.write = bwrite;
      next_cmd.addr  = sram_port_pkg::ADDR_MAX'(hi);
      // Only the two low bits walk; the rest of the start address is kept.
      next_cmd.addr[sram_port_pkg::BURST_BITS-1:0] =
        in_q.order ? (base ^ next_cnt) : (base + next_cnt);
      next_cmd.lanes = bwrite ? ~in_q.lanes_n : '0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      base   <= sram_port_pkg::BURST_RST;
      cnt    <= sram_port_pkg::BURST_RST;
      active <= 1'h0;
      bwrite <= 1'h0;
      hi     <= '0;
    end else if (run) begin
      base   <= next_base;
      cnt    <= next_cnt;
      active <= next_active;
      bwrite <= next_bwrite;
      hi     <= next_hi;
    end
  end

  // ----------------------------------------------------------------
  // Pipeline stages
  // ----------------------------------------------------------------
  // Stages keep moving after a deselect, so earlier commands still finish.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s1 <= sram_port_pkg::CMD_IDLE;
      s2 <= sram_port_pkg::CMD_IDLE;
    end else if (run) begin
      s1 <= next_cmd;
      s2 <= s1;
    end
  end

  // Write data is taken on the same edge that a read would launch its data.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      din_q <= '0;
    end else if (run) begin
      din_q <= DATA_IN;
    end
  end

  // ----------------------------------------------------------------
  // Array and byte lanes
  // ----------------------------------------------------------------
  // A write commits one edge after its data is taken; a read right behind it
  // would otherwise see the old word, so matching lanes are forwarded.
  assign hit = s2.valid && s2.write && (s2.addr == s1.addr);

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    localparam int LO = l * sram_port_pkg::LANE_BITS;
    assign wr_word[LO +: sram_port_pkg::LANE_BITS] = s2.lanes[l] ?
      din_q[LO +: sram_port_pkg::LANE_BITS] :
      mem[s2.addr[ADDR_W-1:0]][LO +: sram_port_pkg::LANE_BITS];
    assign rd_word[LO +: sram_port_pkg::LANE_BITS] = (hit && s2.lanes[l]) ?
      din_q[LO +: sram_port_pkg::LANE_BITS] :
      mem[s1.addr[ADDR_W-1:0]][LO +: sram_port_pkg::LANE_BITS];
  end

  always_ff @(posedge CORE_CLK) begin
    if (run && s2.valid && s2.write) begin
      mem[s2.addr[ADDR_W-1:0]] <= wr_word;
    end
  end

  // ----------------------------------------------------------------
  // Data output
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DATA_OUT <= '0;
      drive    <= 1'h0;
    end else if (run) begin
      // Read of the cycle before last launches now; write or idle floats.
      drive <= s1.valid && !s1.write;
      if (s1.valid && !s1.write) begin
        DATA_OUT <= rd_word;
      end
    end
  end

  // Output enable is asynchronous, so it gates the registered drive directly.
  assign DATA_OE_N = !drive || OUTPUT_ENABLE_N;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence q_read_load;
    !CLOCK_SUSPEND_N && !ADVANCE_OR_LOAD && READ_NOT_WRITE &&
    !CHIP_SELECT_LOW_A && !CHIP_SELECT_LOW_B && CHIP_SELECT_PAIR;
  endsequence

  property p_read_two_later;
    @(posedge CORE_CLK) disable iff (RST)
    q_read_load ##1 !CLOCK_SUSPEND_N ##1 !CLOCK_SUSPEND_N |=> drive;
  endproperty
  a_read_two_later: assert property (p_read_two_later)
    else $error("Read data did not launch two cycles after the command.");

  property p_write_floats;
    @(posedge CORE_CLK) disable iff (RST)
    (!CLOCK_SUSPEND_N && !ADVANCE_OR_LOAD && !READ_NOT_WRITE) ##1 !CLOCK_SUSPEND_N
      ##1 !CLOCK_SUSPEND_N |=> !drive;
  endproperty
  a_write_floats: assert property (p_write_floats)
    else $error("Bus still driven two cycles after a write was sampled.");

  // The burst flag clears one counted edge after the deselect and the bus floats one
  // edge later; a selected load right behind the deselect may set the flag again.
  property p_deselect_floats;
    @(posedge CORE_CLK) disable iff (RST)
    (!CLOCK_SUSPEND_N && !ADVANCE_OR_LOAD && CHIP_SELECT_LOW_A) ##1 !CLOCK_SUSPEND_N
      |=> !active and (!CLOCK_SUSPEND_N |=> !drive);
  endproperty
  a_deselect_floats: assert property (p_deselect_floats)
    else $error("Bus still driven two cycles after a deselect.");

  property p_no_new_op;
    @(posedge CORE_CLK) disable iff (RST)
    (!CLOCK_SUSPEND_N && !ADVANCE_OR_LOAD && !CHIP_SELECT_PAIR) ##1 !CLOCK_SUSPEND_N
      |=> !s1.valid;
  endproperty
  a_no_new_op: assert property (p_no_new_op)
    else $error("A deselected load started an operation.");

  property p_inflight_completes;
    @(posedge CORE_CLK) disable iff (RST)
    q_read_load ##1 (!CLOCK_SUSPEND_N && !ADVANCE_OR_LOAD && CHIP_SELECT_LOW_B)
      ##1 !CLOCK_SUSPEND_N |=> drive and (!CLOCK_SUSPEND_N |=> !drive);
  endproperty
  a_inflight_completes: assert property (p_inflight_completes)
    else $error("A deselect cancelled a read already in the pipeline.");

  property p_suspend_holds;
    @(posedge CORE_CLK) disable iff (RST)
    CLOCK_SUSPEND_N |=> $stable(s1) && $stable(s2) && $stable(drive) && $stable(cnt);
  endproperty
  a_suspend_holds: assert property (p_suspend_holds)
    else $error("State changed while the clock was suspended.");

  property p_burst_order;
    @(posedge CORE_CLK) disable iff (RST)
    (run && !in_q.load && active) |=> s1.valid &&
      (in_q.order ? ((s1.addr[1:0] ^ base) == cnt) : ((s1.addr[1:0] - base) == cnt));
  endproperty
  a_burst_order: assert property (p_burst_order)
    else $error("Burst address does not follow the selected order.");

  property p_four_beats;
    @(posedge CORE_CLK) disable iff (RST)
    q_read_load ##1 (!CLOCK_SUSPEND_N && ADVANCE_OR_LOAD) [*3] ##1 !CLOCK_SUSPEND_N
      ##1 !CLOCK_SUSPEND_N |-> $past(drive, 2) && $past(drive) && drive ##1 drive;
  endproperty
  a_four_beats: assert property (p_four_beats)
    else $error("Burst did not give four read data cycles.");

  // An advance after a deselected load must not resume the old burst.
  property p_burst_ends;
    @(posedge CORE_CLK) disable iff (RST)
    (!CLOCK_SUSPEND_N && !ADVANCE_OR_LOAD && CHIP_SELECT_LOW_A)
      ##1 (!CLOCK_SUSPEND_N && ADVANCE_OR_LOAD) ##1 !CLOCK_SUSPEND_N |=> !s1.valid;
  endproperty
  a_burst_ends: assert property (p_burst_ends)
    else $error("An advance after a deselect continued the old burst.");

  property p_oe_async;
    @(posedge CORE_CLK) disable iff (RST)
    OUTPUT_ENABLE_N |-> DATA_OE_N;
  endproperty
  a_oe_async: assert property (p_oe_async)
    else $error("Data driven while output enable is inactive.");

  c_burst_read: cover property (@(posedge CORE_CLK) disable iff (RST) drive [*4]);
  c_turnaround: cover property (@(posedge CORE_CLK) disable iff (RST)
    s2.valid && s2.write && s1.valid && !s1.write && hit);
  c_suspend_mid: cover property (@(posedge CORE_CLK) disable iff (RST)
    s1.valid ##1 CLOCK_SUSPEND_N [*2] ##1 drive);
  c_interleaved: cover property (@(posedge CORE_CLK) disable iff (RST)
    run && in_q.order && !in_q.load && active);
  c_deselect_in_flight: cover property (@(posedge CORE_CLK) disable iff (RST)
    run && s1.valid && !s1.write && in_q.load && !in_q.sel);

endmodule : pipelined_burst_sram_port

// [sram_ctrl_model.sv]
// Purpose: Memory controller model that drives the command pins and the write data lines.
// Assumes: It shares CORE_CLK with the memory port; commands arrive through the drive task.
// Notes:   Outside write slots the data lines toggle, so stale data is never read as valid.
module sram_ctrl_model (
  input  wire logic        clk,
  input  wire logic        rst,
  output logic             suspend,
  output logic             cs_a,
  output logic             cs_b,
  output logic             cs_pair,
  output logic             adv,
  output logic             rnw,
  output logic [16:0]      addr,
  output logic [3:0]       lanes_n,
  output logic [35:0]      data_in
);
  logic        wr_burst;
  logic        pend_v;
  logic [35:0] pend_d;
  logic [35:0] wd;
  wire         selected = !cs_a && !cs_b && cs_pair;
  wire         wr_now   = (!adv && selected && !rnw) || (adv && wr_burst);

  initial begin
    suspend = 1'h0;
    cs_a    = 1'h1;
    cs_b    = 1'h0;
    cs_pair = 1'h1;
    adv     = 1'h0;
    rnw     = 1'h1;
    addr    = 17'h0_0000;
    lanes_n = 4'hF;
    wd      = 36'h0;
  end

  // Every pin changes just after an edge and holds for the whole cycle.
  task automatic drive(input logic s, input logic [2:0] cs, input sram_port_pkg::pin_t p,
                       input logic [35:0] d);
    @(posedge clk);
    suspend <= s;
    {cs_pair, cs_b, cs_a} <= cs;
    adv     <= !p.load;
    rnw     <= p.rd;
    addr    <= p.addr[16:0];
    lanes_n <= p.lanes_n;
    wd      <= d;
  endtask : drive

  // ----------------------------------------------------------------
  // Write data slot, two counted edges after the command edge
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_burst <= 1'h0;
      pend_v   <= 1'h0;
      data_in  <= 36'h0;
    end else if (!suspend) begin
      if (!adv) begin
        wr_burst <= selected && !rnw;
      end
      pend_v  <= wr_now;
      pend_d  <= wd;
      data_in <= pend_v ? pend_d : ~data_in;
    end
  end
endmodule : sram_ctrl_model

// [pipelined_burst_sram_port_tb_top.sv]
// Purpose: Self-checking bench comparing the memory port with a cycle model of its pipeline.
// Assumes: Default 36-bit organisation; traffic stays in the first 64 words, all filled first.
// Notes:   Expected data comes from an associative array updated as writes reach the bus.
module pipelined_burst_sram_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [2:0] SEL = 3'h4;
  logic        clk;
  logic        rst;
  logic        oe_n;
  logic        order;
  logic        suspend, cs_a, cs_b, cs_pair, adv, rnw, data_oe_n;
  logic [16:0] addr, base, a1, a2;
  logic [3:0]  lanes_n, l1, l2;
  logic [35:0] data_in, data_out, exp_data;
  logic [35:0] mem [int];
  logic [31:0] seed = 32'h3b95_6b3b;
  logic [1:0]  bk;
  logic        bact, brd, v1, r1, v2, r2, exp_drive, exp_known;
  int          failures = 0;
  int          n_checks = 0;

  pipelined_burst_sram_port i_dut (.CORE_CLK(clk), .RST(rst), .CLOCK_SUSPEND_N(suspend),
    .CHIP_SELECT_LOW_A(cs_a), .CHIP_SELECT_LOW_B(cs_b), .CHIP_SELECT_PAIR(cs_pair),
    .ADVANCE_OR_LOAD(adv), .READ_NOT_WRITE(rnw), .WORD_ADDRESS(addr),
    .BYTE_LANE_WRITE_N(lanes_n), .BURST_ORDER_SEL(order), .OUTPUT_ENABLE_N(oe_n),
    .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE_N(data_oe_n));
  sram_ctrl_model i_ctrl (.clk(clk), .rst(rst), .suspend(suspend), .cs_a(cs_a), .cs_b(cs_b),
    .cs_pair(cs_pair), .adv(adv), .rnw(rnw), .addr(addr), .lanes_n(lanes_n),
    .data_in(data_in));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // ----------------------------------------------------------------
  // Reference pipeline: suspended edges leave every stage untouched
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {bact, v1, v2, exp_drive, exp_known} = 5'h00;
      exp_data = 36'h0;
    end else if (!suspend) begin
      if (v2 && !r2) begin
        if (!mem.exists(a2)) mem[a2] = 36'h0;
        for (int l = 0; l < 4; l++) if (!l2[l]) mem[a2][9*l +: 9] = data_in[9*l +: 9];
      end
      exp_drive = v2 && r2;
      if (exp_drive) begin
        exp_known = mem.exists(a2);
        if (exp_known) exp_data = mem[a2];
      end
      {v2, r2, a2, l2} = {v1, r1, a1, l1};
      if (!adv) begin
        bact = !cs_a && !cs_b && cs_pair;
        brd  = rnw;
        base = addr;
        bk   = 2'h0;
      end else begin
        bk = bk + 2'h1;
      end
      v1 = bact;
      r1 = brd;
      a1 = {base[16:2], order ? base[1:0] ^ bk : base[1:0] + bk};
      l1 = lanes_n;
    end
  end

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  always @(posedge clk) begin
    #1;
    if (!rst) begin
      check("DATA_OE_N", {35'h0, !exp_drive || oe_n}, {35'h0, data_oe_n});
      if (exp_drive && exp_known) check("DATA_OUT", exp_data, data_out);
    end
  end

  task automatic op(input logic s, input logic [2:0] cs, input logic ld, input logic rd,
                    input logic [5:0] a, input logic [3:0] ln, input logic [35:0] d);
    sram_port_pkg::pin_t p;
    p         = sram_port_pkg::PIN_RST;
    p.load    = ld;
    p.rd      = rd;
    p.addr    = {12'h000, a};
    p.lanes_n = ln;
    i_ctrl.drive(s, cs, p, d);
  endtask : op

  task automatic idle(input int n);
    repeat (n) op(1'h0, 3'h5, 1'h1, 1'h1, 6'h00, 4'hF, 36'h0);
  endtask : idle

  // Suspends, all deselect codes, bursts and byte lanes come from one random stream.
  task automatic run_random(input int n, input logic o);
    logic [31:0] r;
    logic [2:0]  cs;
    idle(3);
    order <= o;
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      r    = seed;
      seed = lfsr(seed);
      cs   = {r[6], r[7], r[8]};
      if (r[5:3] != 3'h0 || cs == SEL) cs = (r[5:3] != 3'h0) ? SEL : 3'h5;
      oe_n <= &r[24:22];
      op(r[2:0] == 3'h0, cs, r[9], r[11], r[17:12], r[21:18], {seed[3:0], seed});
    end
    idle(3);
    $display("test random order %0d done", o);
  endtask : run_random

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    rst   = 1'h1;
    oe_n  = 1'h0;
    order = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    check("DATA_OUT reset", 36'h0, data_out);
    check("DATA_OE_N reset", 36'h1, {35'h0, data_oe_n});
    @(posedge clk);
    rst <= 1'h0;
    for (int a = 0; a < 64; a++) begin
      seed = lfsr(seed);
      op(1'h0, SEL, a % 4 == 0, 1'h0, 6'(a), 4'h0, {seed[3:0], seed});
    end
    idle(3);
    $display("test fill done");
    op(1'h0, SEL, 1'h1, 1'h0, 6'h07, 4'h0, 36'h5_A5A5_A5A5);
    op(1'h0, SEL, 1'h1, 1'h1, 6'h07, 4'hF, 36'h0);
    idle(3);
    $display("test turnaround done");
    run_random(400, 1'h0);
    run_random(400, 1'h1);
    stop_test;
  end

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    $display("mismatch run_length expected finish seen timeout");
    stop_test;
  end
endmodule : pipelined_burst_sram_port_tb_top
